/* File: rtl/sport_pkg.sv */
/*
 * Shared constants and types of the serial port: register map, control
 * layout, pin bundles and mode enumerations.
 * Assumes a 125 MHz pclk, which is also the timing base of the port.
 */
package sport_pkg;

	// register byte offsets
	localparam logic [11:0] CTRL_OFF = 12'h000;
	localparam logic [11:0] TXDATA_OFF = 12'h004;
	localparam logic [11:0] RXDATA_OFF = 12'h008;
	localparam logic [11:0] STATUS_OFF = 12'h00C;

	// status bit positions
	localparam int STAT_TX_SPACE = 0;
	localparam int STAT_TX_EMPTY = 1;
	localparam int STAT_TX_BUSY = 2;
	localparam int STAT_RX_VALID = 3;

	// timing base
	localparam int CLK_MHZ = 125;
	localparam int TX_EXT_NS = 16;
	localparam logic [1:0] TX_EXT_CYCLES = 2'((TX_EXT_NS * CLK_MHZ + 999) / 1000);

	typedef enum logic [1:0] {SRC_CPU, SRC_TX_PIN, SRC_RX_PIN} src_e;
	typedef enum logic [1:0] {TX_IDLE, TX_DELAY, TX_SHIFT} tx_state_e;
	typedef enum logic [1:0] {RX_IDLE, RX_DELAY, RX_SHIFT} rx_state_e;

	// control register, lsb first from the bottom of the list
	typedef struct packed {
		logic [1:0] clock_source;
		logic enable;
		logic tx_output_enable_extend;
		logic [1:0] tx_data_delay_select;
		logic rx_sync_polarity;
		logic tx_sync_polarity;
		logic rx_clock_polarity;
		logic tx_clock_polarity;
		logic [7:0] rate_divider_value;
	} ctrl_s;

	localparam int CTRL_W = 18;
	localparam logic [17:0] CTRL_RST = 18'h00001;

	typedef struct packed {
		logic tx_shift_clock_pin;
		logic rx_shift_clock_pin;
		logic rx_frame_sync_pin;
		logic rx_serial_data_pin;
	} pin_in_s;

	typedef struct packed {
		logic tx_shift_clock_pin;
		logic tx_shift_clock_pin_oe;
		logic rx_shift_clock_pin;
		logic rx_shift_clock_pin_oe;
		logic tx_frame_sync_pin;
		logic tx_frame_sync_pin_oe;
		logic tx_serial_data_pin;
		logic tx_serial_data_pin_oe;
	} pin_out_s;

endpackage : sport_pkg

/* File: rtl/rate_divider.sv */
/*
 * Rate generator: divides a tick stream into the shift clock and gives
 * one-cycle rise and fall markers aligned with the clock's edges.
 * Assumes tick is synchronous to pclk; tick is 1 for the CPU clock source.
 */
`timescale 1ns/10ps
module rate_divider #(
	parameter int DIV_W = 8
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// control
	input wire logic tick,
	input wire logic [DIV_W-1:0] div,
	// generated clock
	output logic clkg,
	output logic rise,
	output logic fall
);
	import sport_pkg::*;

	initial
	begin
		if (DIV_W < 2 || DIV_W > 16)
			$error("rate_divider: DIV_W out of range");
	end

	typedef struct packed {
		logic [DIV_W-1:0] cnt;
		logic clkg;
		logic rise;
		logic fall;
	} div_s;

	div_s st_r;
	div_s st_nxt;
	logic [DIV_W-1:0] eff;
	logic [DIV_W-1:0] high_len;

	always_comb
	begin
		// a zero divider cannot be made from pclk flops; it runs as one
		eff = (div == '0) ? DIV_W'(1) : div;
		// period eff+1 ticks; high (eff>>1)+1 covers odd and even alike
		high_len = DIV_W'((eff >> 1) + 1'b1);
		st_nxt = st_r;
		st_nxt.rise = 1'b0;
		st_nxt.fall = 1'b0;
		if (tick)
		begin
			if (st_r.cnt >= eff)
			begin
				st_nxt.cnt = '0;
				st_nxt.clkg = 1'b1;
				st_nxt.rise = 1'b1;
			end
			else
			begin
				st_nxt.cnt = st_r.cnt + 1'b1;
				if (st_nxt.cnt == high_len)
				begin
					st_nxt.clkg = 1'b0;
					st_nxt.fall = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st_r <= '{cnt: '1, clkg: 1'b0, rise: 1'b0, fall: 1'b0};
		else
			st_r <= st_nxt;
	end

	assign clkg = st_r.clkg;
	assign rise = st_r.rise;
	assign fall = st_r.fall;

	// helper tick counters per phase, valid once a full phase was seen
	logic [DIV_W:0] hcnt;
	logic [DIV_W:0] lcnt;
	logic [DIV_W:0] hlast;
	logic seen;
	logic seen_1;
	logic [DIV_W-1:0] div_q;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			hcnt <= '0;
			lcnt <= '0;
			hlast <= '0;
			seen <= 1'b0;
			seen_1 <= 1'b0;
			div_q <= '0;
		end
		else
		begin
			div_q <= div;
			// the period cut by a divider change may run long, so skip it
			if (div != div_q)
			begin
				seen <= 1'b0;
				seen_1 <= 1'b0;
			end
			else if (st_r.fall)
			begin
				seen <= seen_1;
				seen_1 <= 1'b1;
			end
			if (st_r.fall)
				hlast <= hcnt;
			hcnt <= st_r.fall ? '0 : hcnt + (DIV_W+1)'(st_r.clkg & tick);
			lcnt <= st_r.rise ? '0 : lcnt + (DIV_W+1)'(!st_r.clkg & tick);
		end
	end

	AST_HIGH_WIDTH: assert property (@(posedge pclk) disable iff (!presetn)
		st_r.fall && seen && div == div_q |-> hcnt == (DIV_W+1)'(high_len))
		else $error("shift clock high phase has wrong length");

	AST_LOW_WIDTH: assert property (@(posedge pclk) disable iff (!presetn)
		st_r.rise && seen && div == div_q |-> lcnt == (DIV_W+1)'(eff) + 1'b1 - high_len)
		else $error("shift clock low phase has wrong length");

	AST_PERIOD: assert property (@(posedge pclk) disable iff (!presetn)
		st_r.rise && seen && div == div_q |-> lcnt + hlast == (DIV_W+1)'(eff) + 1'b1)
		else $error("shift clock period differs from divider plus one");

endmodule : rate_divider

/* File: rtl/word_buffer.sv */
/*
 * Small flop-based FIFO with valid/ready on both sides.
 * Assumes one clock; a full buffer drops in_ready so the writer stalls.
 */
`timescale 1ns/10ps
module word_buffer #(
	parameter int W = 16,
	parameter int DEPTH = 2
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	import sport_pkg::*;

	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	initial
	begin
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || W < 1)
			$error("word_buffer: DEPTH must be a power of two >= 2");
	end

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [PW-1:0] wp;
		logic [PW-1:0] rp;
		logic [PW:0] cnt;
	} buf_s;

	buf_s st_r;
	buf_s st_nxt;
	logic push;
	logic pop;

	always_comb
	begin
		in_ready = st_r.cnt != (PW+1)'(DEPTH);
		out_valid = st_r.cnt != '0;
		out_data = st_r.mem[st_r.rp];
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		st_nxt = st_r;
		if (push)
		begin
			st_nxt.mem[st_r.wp] = in_data;
			st_nxt.wp = st_r.wp + 1'b1;
		end
		if (pop)
			st_nxt.rp = st_r.rp + 1'b1;
		st_nxt.cnt = st_r.cnt + (PW+1)'(push) - (PW+1)'(pop);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

endmodule : word_buffer

/* File: rtl/buffered_serial_port.sv */
/*
 * Buffered serial port: APB registers, rate generator, transmit framer
 * with data delay and output-enable extension, receive sampler.
 * Assumes pclk is the CPU clock (2H = one cycle) and pins are buffered
 * outside from the output enables; pin inputs are asynchronous.
 */
// Register access over APB and the address map were decided locally.
`timescale 1ns/10ps
module buffered_serial_port #(
	parameter int WLEN = 16,
	parameter int AW = 12
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// serial pins
	input wire sport_pkg::pin_in_s pins_in,
	output sport_pkg::pin_out_s pins_out
);
	import sport_pkg::*;

	localparam int CW = $clog2(WLEN);

	initial
	begin
		if (WLEN < 2 || WLEN > 32 || AW < 4)
			$error("buffered_serial_port: WLEN must be 2..32, AW at least 4");
	end

	function automatic logic hit(input logic [AW-1:0] a, input logic [11:0] off);
		hit = a == AW'(off);
	endfunction : hit

	typedef struct packed {
		ctrl_s ctrl;
		logic [31:0] prdata;
		pin_in_s s1;
		pin_in_s s2;
		pin_in_s s3;
		tx_state_e tx_st;
		logic [1:0] tdcnt;
		logic [WLEN-1:0] tsh;
		logic [CW-1:0] tcnt;
		logic tbit;
		logic toe;
		logic [1:0] ext_cnt;
		logic fs;
		rx_state_e rx_st;
		logic [1:0] rdcnt;
		logic [WLEN-1:0] rsh;
		logic [CW-1:0] rcnt;
		logic [WLEN-1:0] rword;
		logic rvalid;
	} st_s;

	st_s st_r;
	st_s st_nxt;

	logic tick;
	logic clkg;
	logic rise;
	logic fall;
	logic acc;
	logic tx_wr;
	logic rx_rd;
	logic mapped;
	logic buf_ready;
	logic buf_valid;
	logic buf_pop;
	logic [WLEN-1:0] buf_word;
	logic launch;
	logic rtake;
	logic rfs;
	src_e src;

	// clock source select; an illegal code falls back to the CPU clock
	always_comb
	begin
		unique case (st_r.ctrl.clock_source)
			2'h1: src = SRC_TX_PIN;
			2'h2: src = SRC_RX_PIN;
			default: src = SRC_CPU;
		endcase
	end

	// a pin as generator input counts its synchronised rising edges
	always_comb
	begin
		unique case (src)
			SRC_TX_PIN: tick = st_r.s2.tx_shift_clock_pin & ~st_r.s3.tx_shift_clock_pin;
			SRC_RX_PIN: tick = st_r.s2.rx_shift_clock_pin & ~st_r.s3.rx_shift_clock_pin;
			SRC_CPU: tick = 1'b1;
		endcase
	end

	rate_divider #(
		.DIV_W(8)
	) u_div (
		.pclk(pclk),
		.presetn(presetn),
		.tick(tick),
		.div(st_r.ctrl.rate_divider_value),
		.clkg(clkg),
		.rise(rise),
		.fall(fall)
	);

	word_buffer #(
		.W(WLEN),
		.DEPTH(2)
	) u_txbuf (
		.pclk(pclk),
		.presetn(presetn),
		.in_valid(tx_wr),
		.in_ready(buf_ready),
		.in_data(pwdata[WLEN-1:0]),
		.out_valid(buf_valid),
		.out_ready(buf_pop),
		.out_data(buf_word)
	);

	always_comb
	begin
		acc = psel && penable;
		mapped = hit(paddr, CTRL_OFF) || hit(paddr, TXDATA_OFF)
			|| hit(paddr, RXDATA_OFF) || hit(paddr, STATUS_OFF);
		tx_wr = acc && pwrite && hit(paddr, TXDATA_OFF);
		// a full transmit buffer holds the write in its access phase
		pready = !(tx_wr && !buf_ready);
		pslverr = acc && !mapped;
		rx_rd = acc && !pwrite && hit(paddr, RXDATA_OFF);
		buf_pop = rise && st_r.ctrl.enable && st_r.tx_st == TX_IDLE && buf_valid;
		rfs = st_r.s2.rx_frame_sync_pin ^ st_r.ctrl.rx_sync_polarity;
	end

	always_comb
	begin
		st_nxt = st_r;
		launch = 1'b0;
		rtake = 1'b0;
		// pins pass two flops before any logic reads them
		st_nxt.s1 = pins_in;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;

		// read data is set up in the setup phase so reads need no wait
		if (psel && !penable && !pwrite)
		begin
			st_nxt.prdata = '0;
			if (hit(paddr, CTRL_OFF))
				st_nxt.prdata = 32'(st_r.ctrl);
			else if (hit(paddr, RXDATA_OFF))
				st_nxt.prdata = 32'(st_r.rword);
			else if (hit(paddr, STATUS_OFF))
			begin
				st_nxt.prdata[STAT_TX_SPACE] = buf_ready;
				st_nxt.prdata[STAT_TX_EMPTY] = !buf_valid;
				st_nxt.prdata[STAT_TX_BUSY] = st_r.tx_st != TX_IDLE;
				st_nxt.prdata[STAT_RX_VALID] = st_r.rvalid;
			end
		end
		if (acc && pwrite && hit(paddr, CTRL_OFF))
			st_nxt.ctrl = ctrl_s'(pwdata[CTRL_W-1:0]);

		// output-enable extension countdown
		if (st_r.ext_cnt != '0)
		begin
			st_nxt.ext_cnt = st_r.ext_cnt - 1'b1;
			if (st_r.ext_cnt == 2'h1)
				st_nxt.toe = 1'b1;
		end

		// transmit: all changes follow a rising shift clock edge
		if (rise)
		begin
			st_nxt.fs = 1'b0;
			unique case (st_r.tx_st)
				TX_IDLE:
				begin
					if (buf_pop)
					begin
						st_nxt.fs = 1'b1;
						st_nxt.tsh = buf_word;
						if (st_r.ctrl.tx_data_delay_select == 2'h0)
							launch = 1'b1;
						else
						begin
							st_nxt.tdcnt = st_r.ctrl.tx_data_delay_select - 1'b1;
							st_nxt.tx_st = TX_DELAY;
						end
					end
				end
				TX_DELAY:
				begin
					if (st_r.tdcnt == '0)
						launch = 1'b1;
					else
						st_nxt.tdcnt = st_r.tdcnt - 1'b1;
				end
				TX_SHIFT:
				begin
					if (st_r.tcnt == '0)
					begin
						st_nxt.toe = 1'b0;
						st_nxt.ext_cnt = '0;
						st_nxt.tx_st = TX_IDLE;
					end
					else
					begin
						st_nxt.tbit = st_r.tsh[WLEN-1];
						st_nxt.tsh = {st_r.tsh[WLEN-2:0], 1'b0};
						st_nxt.tcnt = st_r.tcnt - 1'b1;
					end
				end
			endcase
		end
		if (launch)
		begin
			st_nxt.tbit = st_nxt.tsh[WLEN-1];
			st_nxt.tsh = {st_nxt.tsh[WLEN-2:0], 1'b0};
			st_nxt.tcnt = CW'(WLEN - 1);
			st_nxt.tx_st = TX_SHIFT;
			if (st_r.ctrl.tx_output_enable_extend)
				st_nxt.ext_cnt = TX_EXT_CYCLES;
			else
				st_nxt.toe = 1'b1;
		end

		// receive: frame sync and data both taken on the falling edge
		if (fall)
		begin
			unique case (st_r.rx_st)
				RX_IDLE:
				begin
					if (st_r.ctrl.enable && rfs)
					begin
						st_nxt.rcnt = '0;
						if (st_r.ctrl.tx_data_delay_select == 2'h0)
							rtake = 1'b1;
						else
						begin
							st_nxt.rdcnt = st_r.ctrl.tx_data_delay_select - 1'b1;
							st_nxt.rx_st = RX_DELAY;
						end
					end
				end
				RX_DELAY:
				begin
					if (st_r.rdcnt == '0)
						rtake = 1'b1;
					else
						st_nxt.rdcnt = st_r.rdcnt - 1'b1;
				end
				RX_SHIFT: rtake = 1'b1;
			endcase
		end
		if (rtake)
		begin
			st_nxt.rsh = {st_nxt.rsh[WLEN-2:0], st_r.s2.rx_serial_data_pin};
			st_nxt.rx_st = RX_SHIFT;
			if (st_nxt.rcnt == CW'(WLEN - 1))
			begin
				st_nxt.rword = st_nxt.rsh;
				st_nxt.rx_st = RX_IDLE;
			end
			else
				st_nxt.rcnt = st_nxt.rcnt + 1'b1;
		end
		// a word completing in the reading cycle keeps the flag set
		st_nxt.rvalid = (st_r.rvalid && !rx_rd)
			|| (rtake && st_nxt.rx_st == RX_IDLE);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_r <= '0;
			st_r.ctrl <= ctrl_s'(CTRL_RST);
		end
		else
			st_r <= st_nxt;
	end

	always_comb
	begin
		prdata = st_r.prdata;
		// the generator output leaves on the pin that is not its input
		pins_out.tx_shift_clock_pin = clkg ^ st_r.ctrl.tx_clock_polarity;
		pins_out.tx_shift_clock_pin_oe = src != SRC_TX_PIN;
		pins_out.rx_shift_clock_pin = clkg ^ st_r.ctrl.rx_clock_polarity;
		pins_out.rx_shift_clock_pin_oe = src != SRC_RX_PIN;
		pins_out.tx_frame_sync_pin = st_r.fs ^ st_r.ctrl.tx_sync_polarity;
		pins_out.tx_frame_sync_pin_oe = 1'b1;
		pins_out.tx_serial_data_pin = st_r.tbit;
		pins_out.tx_serial_data_pin_oe = st_r.toe;
	end

	AST_FS_AFTER_RISE: assert property (@(posedge pclk) disable iff (!presetn)
		$changed(st_r.fs) |-> $past(rise))
		else $error("frame sync changed without a rising shift clock edge");

	AST_BIT_AFTER_RISE: assert property (@(posedge pclk) disable iff (!presetn)
		$changed(st_r.tbit) |-> $past(rise) && $past(st_r.tx_st) != TX_IDLE
			|| $past(st_r.ctrl.tx_data_delay_select) == 2'h0)
		else $error("data bit changed off a rising shift clock edge");

	AST_DLY0_FIRST: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(st_r.fs) && st_r.tx_st == TX_SHIFT && !st_r.ctrl.tx_output_enable_extend
			|-> st_r.toe && st_r.tcnt == CW'(WLEN - 1))
		else $error("zero delay first bit not driven with frame sync");

	AST_DLY12_FIRST: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(st_r.toe) && $past(st_r.tx_st) == TX_DELAY |-> $past(rise))
		else $error("delayed first bit not launched on a rising edge");

	AST_EXT_DELAY: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(st_r.tx_st == TX_SHIFT) && st_r.ctrl.tx_output_enable_extend
			|-> !st_r.toe ##1 !st_r.toe ##1 st_r.toe)
		else $error("extended enable not two cycles late");

	AST_RELEASE: assert property (@(posedge pclk) disable iff (!presetn)
		rise && st_r.tx_st == TX_SHIFT && st_r.tcnt == '0 |=> !pins_out.tx_serial_data_pin_oe)
		else $error("data pin not released after last bit");

	AST_RX_ON_FALL: assert property (@(posedge pclk) disable iff (!presetn)
		$changed(st_r.rsh) |-> $past(fall))
		else $error("receive data taken off a falling edge");

	AST_RX_FS_ON_FALL: assert property (@(posedge pclk) disable iff (!presetn)
		$past(st_r.rx_st) == RX_IDLE && st_r.rx_st != RX_IDLE |-> $past(fall) && $past(rfs))
		else $error("receive frame start not on a falling edge with sync");

	AST_PIN_SOURCE: assert property (@(posedge pclk) disable iff (!presetn)
		src != SRC_CPU |-> pins_out.tx_shift_clock_pin_oe != pins_out.rx_shift_clock_pin_oe)
		else $error("common clock not driven on exactly one pin");

	COV_DLY0: cover property (@(posedge pclk) disable iff (!presetn)
		$rose(st_r.fs) && st_r.ctrl.tx_data_delay_select == 2'h0);
	COV_EXT: cover property (@(posedge pclk) disable iff (!presetn)
		$rose(st_r.toe) && st_r.ctrl.tx_output_enable_extend);
	COV_PIN_SRC: cover property (@(posedge pclk) disable iff (!presetn)
		rise && src == SRC_RX_PIN);
	COV_RX_WORD: cover property (@(posedge pclk) disable iff (!presetn)
		$rose(st_r.rvalid));

endmodule : buffered_serial_port

/* File: verification/serial_peer.sv */
/*
 * Far-side serial device: captures sent words, sends receive frames and
 * runs a source clock for the pin-clock modes.
 * Assumes default clock polarity on the pins that it follows.
 */
`timescale 1ns/10ps
module serial_peer #(
	parameter int WLEN = 16
) (
	// clocks
	input wire logic pclk,
	input wire logic ext_run,
	// port pins
	input wire sport_pkg::pin_out_s pins_out,
	output logic rx_sync,
	output logic rx_data,
	output logic ext_clk,
	// capture
	output logic [WLEN-1:0] cap_word,
	output logic cap_valid,
	output logic [7:0] lag
);
	import sport_pkg::*;
	logic clk_q = 1'b0;
	logic fs_q = 1'b0;
	logic busy = 1'b0;
	logic lag_run = 1'b0;
	logic [WLEN-1:0] sh = '0;
	int nbits = 0;
	int lag_n = 0;
	initial
	begin
		rx_sync = 1'b0;
		rx_data = 1'b0;
		ext_clk = 1'b0;
		cap_valid = 1'b0;
		cap_word = '0;
		lag = '0;
	end
	// source clock of four pclk cycles, slower than the pin sampler's limit
	always #16 ext_clk = ext_run ? ~ext_clk : 1'b0;
	always @(posedge pclk)
	begin
		cap_valid <= 1'b0;
		clk_q <= pins_out.tx_shift_clock_pin;
		fs_q <= pins_out.tx_frame_sync_pin;
		// idle line keeps moving so a stale bit cannot pass for data
		if (!busy)
			rx_data <= ~rx_data;
		if (pins_out.tx_frame_sync_pin && !fs_q)
		begin
			lag_run = 1'b1;
			lag_n = 0;
		end
		if (lag_run && pins_out.tx_serial_data_pin_oe)
		begin
			lag <= 8'(lag_n);
			lag_run = 1'b0;
		end
		lag_n++;
		if (clk_q && !pins_out.tx_shift_clock_pin && pins_out.tx_serial_data_pin_oe)
		begin
			sh = {sh[WLEN-2:0], pins_out.tx_serial_data_pin};
			nbits++;
			if (nbits == WLEN)
			begin
				cap_word <= sh;
				cap_valid <= 1'b1;
				nbits = 0;
			end
		end
	end
	task automatic send_word(input logic [WLEN-1:0] w, input int d);
		busy = 1'b1;
		for (int i = -d; i < WLEN; i++)
		begin
			@(posedge pins_out.rx_shift_clock_pin);
			rx_sync <= (i == -d);
			rx_data <= (i >= 0) ? w[WLEN-1-i] : ~rx_data;
		end
		@(posedge pins_out.rx_shift_clock_pin);
		rx_sync <= 1'b0;
		rx_data <= ~rx_data;
		busy = 1'b0;
	endtask : send_word
endmodule : serial_peer

/* File: verification/tb_top.sv */
/*
 * Self-checking bench of the buffered serial port: APB master, pin wiring,
 * far-side model and a scoreboard of sent words.
 * Assumes the ctrl_s layout of the package for the control word.
 */
`timescale 1ns/10ps
module tb_top;
	import sport_pkg::*;
	localparam int WLEN = 16;
	logic pclk;
	logic presetn;
	logic psel;
	logic penable;
	logic pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	pin_in_s pins_in;
	pin_out_s pins_out;
	logic rx_sync;
	logic rx_data;
	logic ext_clk;
	logic ext_run;
	logic [WLEN-1:0] cap_word;
	logic cap_valid;
	logic [7:0] lag;
	logic [WLEN-1:0] exp_q[$];
	int mismatches = 0;
	int tests_run = 0;
	// shared clock pins: the port's driver wins while its enable is up
	assign pins_in.tx_shift_clock_pin = pins_out.tx_shift_clock_pin_oe ?
		pins_out.tx_shift_clock_pin : ext_clk;
	assign pins_in.rx_shift_clock_pin = pins_out.rx_shift_clock_pin_oe ?
		pins_out.rx_shift_clock_pin : ext_clk;
	assign pins_in.rx_frame_sync_pin = rx_sync;
	assign pins_in.rx_serial_data_pin = rx_data;
	buffered_serial_port #(.WLEN(WLEN), .AW(12)) u_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .pins_in(pins_in), .pins_out(pins_out));
	serial_peer #(.WLEN(WLEN)) u_peer (
		.pclk(pclk), .ext_run(ext_run), .pins_out(pins_out), .rx_sync(rx_sync),
		.rx_data(rx_data), .ext_clk(ext_clk), .cap_word(cap_word),
		.cap_valid(cap_valid), .lag(lag));
	initial
	begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : report_and_stop
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
		output logic [31:0] rdata, output logic serr);
		int n;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 5000);
		rdata = prdata;
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 5000)
		begin
			mismatches++;
			report_and_stop();
		end
		@(posedge pclk);
	endtask : apb
	function automatic logic [31:0] mk_ctrl(input logic [7:0] dv, input logic pol,
		input logic [1:0] src, input logic en, input logic ext, input logic [1:0] dly);
		ctrl_s c;
		c = '0;
		c.rate_divider_value = dv;
		c.tx_clock_polarity = pol;
		c.rx_clock_polarity = pol;
		c.clock_source = src;
		c.enable = en;
		c.tx_output_enable_extend = ext;
		c.tx_data_delay_select = dly;
		return 32'(c);
	endfunction : mk_ctrl
	// cycles the chosen clock pin stays at one level, bounded
	task automatic run_len(input int sel, input logic lvl, output int n);
		n = 0;
		while ((sel ? pins_out.rx_shift_clock_pin : pins_out.tx_shift_clock_pin) === lvl
			&& n < 300)
		begin
			@(posedge pclk);
			n++;
		end
	endtask : run_len
	task automatic measure(input int sel, output int hi, output int lo);
		run_len(sel, 1'b1, hi);
		run_len(sel, 1'b0, lo);
		run_len(sel, 1'b1, hi);
		run_len(sel, 1'b0, lo);
	endtask : measure
	always @(posedge pclk)
		if (cap_valid === 1'b1)
		begin
			if (exp_q.size() == 0)
				check("spare tx word", 32'd1, 32'd0);
			else
				check("tx word", 32'(cap_word), 32'(exp_q.pop_front()));
		end
	initial
	begin
		int divs[6] = '{1, 2, 3, 4, 7, 8};
		int hi, lo, d, eh, el, n;
		logic [WLEN-1:0] w;
		logic [31:0] rd;
		logic err;
		ctrl_s c;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		ext_run = 1'b0;
		void'($urandom(32'h9a32));
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, STATUS_OFF, '0, rd, err);
		check("status after reset", rd, 32'h3);
		apb(1'b0, 12'h010, '0, rd, err);
		check("unmapped error", 32'(err), 32'd1);
		$display("test registers done");
		for (int i = 0; i < 12; i++)
		begin
			d = divs[i / 2];
			apb(1'b1, CTRL_OFF, mk_ctrl(8'(d), 1'(i % 2), 2'd0, 1'b0, 1'b0, 2'd0), rd, err);
			eh = (d % 2) ? (d + 1) / 2 : d / 2 + 1;
			el = d + 1 - eh;
			measure(0, hi, lo);
			check("tx clock high", 32'(hi), 32'((i % 2) ? el : eh));
			check("tx clock low", 32'(lo), 32'((i % 2) ? eh : el));
			measure(1, hi, lo);
			check("rx clock high", 32'(hi), 32'((i % 2) ? el : eh));
			check("rx clock low", 32'(lo), 32'((i % 2) ? eh : el));
		end
		$display("test divider done");
		ext_run <= 1'b1;
		for (int i = 1; i < 3; i++)
		begin
			apb(1'b1, CTRL_OFF, mk_ctrl(8'd2, 1'b0, 2'(i), 1'b0, 1'b0, 2'd0), rd, err);
			measure(2 - i, hi, lo);
			check("pin source period", 32'(hi + lo), 32'd12);
			check("input pin enable", 32'(i == 1 ? pins_out.tx_shift_clock_pin_oe :
				pins_out.rx_shift_clock_pin_oe), 32'd0);
		end
		ext_run <= 1'b0;
		$display("test pin source done");
		for (int i = 0; i < 6; i++)
		begin
			// the high phase must outlast the two-cycle extension before the fall
			apb(1'b1, CTRL_OFF, mk_ctrl(8'd7, 1'b0, 2'd0, 1'b1, 1'(i % 2), 2'(i / 2)), rd, err);
			// three writes: the last one stalls until a frame frees a slot
			repeat (3)
			begin
				w = WLEN'($urandom);
				exp_q.push_back(w);
				apb(1'b1, TXDATA_OFF, 32'(w), rd, err);
			end
			for (n = 0; n < 4000 && exp_q.size() != 0; n++)
				@(posedge pclk);
			repeat (8) @(posedge pclk);
			check("tx drained", 32'(exp_q.size()), 32'd0);
			// a delay bit is one period of eight cycles, the extension two cycles
			check("first bit lag", 32'(lag), 32'((i / 2) * 8 + (i % 2) * 2));
		end
		$display("test transmit done");
		for (int i = 0; i < 3; i++)
		begin
			apb(1'b1, CTRL_OFF, mk_ctrl(8'd7, 1'b0, 2'd0, 1'b1, 1'b0, 2'(i)), rd, err);
			w = WLEN'($urandom);
			u_peer.send_word(w, i);
			rd = '0;
			for (n = 0; n < 50 && rd[STAT_RX_VALID] !== 1'b1; n++)
				apb(1'b0, STATUS_OFF, '0, rd, err);
			apb(1'b0, RXDATA_OFF, '0, rd, err);
			check("rx word", 32'(rd[WLEN-1:0]), 32'(w));
		end
		$display("test receive done");
		// inverted sync polarity idles the frame sync pin high
		rd = mk_ctrl(8'd7, 1'b0, 2'd0, 1'b0, 1'b0, 2'd0);
		c = ctrl_s'(rd[CTRL_W-1:0]);
		c.tx_sync_polarity = 1'b1;
		apb(1'b1, CTRL_OFF, 32'(c), rd, err);
		check("inverted sync idle", 32'(pins_out.tx_frame_sync_pin), 32'd1);
		apb(1'b0, CTRL_OFF, '0, rd, err);
		check("ctrl readback", rd, 32'(c));
		$display("test polarity done");
		report_and_stop();
	end
endmodule : tb_top
